// ===== fault_qualifier.sv
// Delay filter that reports a condition held for a full count
`timescale 1ns/1ps
`default_nettype none
module fault_qualifier #(
	parameter int DELAY_CYC = 2880
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic clk_en,
	// Condition in, qualified result out
	qual_if.filt      q
);
	localparam int W = $clog2(DELAY_CYC + 1);
	logic [W-1:0] cnt_q;

	if (DELAY_CYC < 1) begin : g_chk
		$error("fault_qualifier: DELAY_CYC must be at least 1");
	end

	// R20 restart on clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			if (!q.cond) begin
				cnt_q <= '0;
			end else if (cnt_q != W'(DELAY_CYC)) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Hit only while the condition is still present after the full count
	assign q.hit = q.cond && (cnt_q == W'(DELAY_CYC));
endmodule
`default_nettype wire

// ===== pwm_protection_sequencer.sv
// Protection and operating-state sequencer of a flyback controller
// Notes on behaviour
// R1 - Overload with supply below short threshold stops
// R2 - Auto variant restarts after 1400 ms, repeatedly
// R3 - Latch variant latches off on short
// R4 - Latch input high or low 72us latches
// R5 - Soft-start widens on-time at every start
// R6 - AC cut off enables line capacitor discharge
// R7 - Eight-level quantiser; increment each 56 ms window
// R8 - Discharge pulses 1.5 ms on, 0.5 off
// R9 - Brown-out held 65 ms stops gate pulses
// R10 - Brown-out stop holds supply 11.5 to 12.5
// R11 - Brown-in threshold crossing restarts switching
// R12 - Spread frequency plus minus 7 kHz
// R13 - Over-voltage held 72 us latches off
// R14 - Start at start threshold, stop at stop
// R15 - Lockout forces gate low, clears latch
// R16 - Latched off holds supply 8 to 9
// R17 - Feedback below burst threshold pauses switching
// R18 - 65 kHz nominal, down to 25 kHz
// R19 - Current trip ends each gate pulse
// R20 - Delay counters restart; latch has priority
// R21 - Comparator inputs synchronised before use
`timescale 1ns/1ps
`default_nettype none
module pwm_protection_sequencer
	import pwm_seq_pkg::*;
#(
	parameter int BO_DLY     = BO_DLY_CYC,
	parameter int RESTART    = RESTART_CYC,
	parameter int ACDET      = ACDET_CYC,
	parameter int XCD_ON     = XCD_ON_CYC,
	parameter int XCD_OFF    = XCD_OFF_CYC,
	parameter int SOFT_START = SS_CYC
) (
	// Clock, reset, enable
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	// Current sense comparators
	input  wire logic                 cs_overload,
	input  wire logic                 cs_pwm_trip,
	// Supply comparators
	input  wire logic                 vcc_below_scp,
	input  wire logic                 supply_overvoltage_protect,
	input  wire logic                 vcc_above_start,
	input  wire logic                 vcc_below_stop,
	input  wire logic                 vcc_below_run_hold_low,
	input  wire logic                 vcc_above_run_hold_high,
	input  wire logic                 vcc_below_latch_hold_low,
	input  wire logic                 vcc_above_latch_hold_high,
	// External latch comparators
	input  wire logic                 ext_latch_above_high,
	input  wire logic                 ext_latch_below_low,
	// High-voltage input comparators
	input  wire logic                 vh_below_brown_out,
	input  wire logic                 vh_above_brown_in,
	input  wire logic [VH_LEVELS-2:0] vh_level_therm,
	// Feedback comparators
	input  wire logic                 feedback_below_burst,
	input  wire logic [FB_W-1:0]      feedback_level,
	// Variant strap, high selects latching short protection
	input  wire logic                 latch_variant,
	// Outputs
	output logic                      gate_out,
	output logic                      charger_on,
	output logic                      line_cap_discharge,
	output logic                      ac_present,
	output logic [2:0]                op_state
);
	localparam int RW = $clog2(RESTART + 1);
	localparam int AW = $clog2(ACDET + 1);
	localparam int XW = $clog2(XCD_ON + XCD_OFF + 1);
	localparam int SS_STEP = SOFT_START / PER_MAX_CYC;
	localparam int SW = $clog2(SS_STEP + 1);

	if (SS_STEP < 1 || DITH_CYC > 127 || RESTART < 2 || ACDET < 2
		|| XCD_ON < 1 || XCD_OFF < 1 || BO_DLY < 1) begin : g_chk
		$error("pwm_protection_sequencer: unsupported timing parameter");
	end

	logic [N_SYNC-1:0]    raw;
	logic [N_SYNC-1:0]    sy1_q;
	logic [N_SYNC-1:0]    sv;
	op_state_e            state_q;
	op_state_e            state_d;
	logic                 variant_q;
	logic [Q_NUM-1:0]     hit;
	logic                 scp_now;
	logic                 latch_trip;
	logic [RW-1:0]        restart_q;
	logic [2:0]           vh_lvl_q;
	logic                 vh_inc_q;
	logic [AW-1:0]        win_q;
	logic                 seen_q;
	logic                 ac_lost_q;
	logic [XW-1:0]        xcd_cnt_q;
	logic                 xcd_on_q;
	logic                 sw_en;
	logic [PW-1:0]        per_cnt_q;
	logic [PW-1:0]        per_len_q;
	logic [PW-1:0]        per_d;
	logic [PW-1:0]        on_cnt_q;
	logic [PW-1:0]        ss_lim_q;
	logic [SW-1:0]        ss_div_q;
	logic signed [7:0]    dith_q;
	logic                 dith_up_q;
	logic                 wrap;
	logic                 gate_q;
	logic                 charger_q;
	logic                 xcd_q;

	// R21 two-stage synchroniser
	assign raw = {feedback_level, vh_level_therm, latch_variant,
		vcc_above_latch_hold_high, vcc_below_latch_hold_low,
		vcc_above_run_hold_high, vcc_below_run_hold_low, cs_pwm_trip,
		feedback_below_burst, vh_above_brown_in, vh_below_brown_out,
		vcc_below_stop, vcc_above_start, supply_overvoltage_protect,
		ext_latch_below_low, ext_latch_above_high, vcc_below_scp,
		cs_overload};

	always_ff @(posedge mclk) begin
		if (rst) begin
			sy1_q <= '0;
			sv    <= '0;
		end else if (clk_en) begin
			sy1_q <= raw;
			sv    <= sy1_q;
		end
	end

	// Strap is taken while in lockout and held through operation
	always_ff @(posedge mclk) begin
		if (rst) begin
			variant_q <= 1'b0;
		end else if (clk_en && state_q == ST_UNDERVOLTAGE_LOCKOUT) begin
			variant_q <= sv[S_VARIANT];
		end
	end

	// R4 R13 R9 qualification delays per channel
	for (genvar i = 0; i < Q_NUM; i++) begin : g_qual
		localparam int D = (i == Q_BO) ? BO_DLY :
			(i == Q_OV) ? OV_DLY_CYC : LAT_DLY_CYC;
		qual_if qi ();
		always_comb begin
			case (i)
				Q_LAT_HI: qi.cond = state_q != ST_UNDERVOLTAGE_LOCKOUT && sv[S_LAT_HI];
				Q_LAT_LO: qi.cond = state_q != ST_UNDERVOLTAGE_LOCKOUT && sv[S_LAT_LO];
				Q_OV:     qi.cond = state_q != ST_UNDERVOLTAGE_LOCKOUT && sv[S_OV];
				default:  qi.cond = state_q == ST_RUN && sv[S_VH_BO];
			endcase
		end
		fault_qualifier #(.DELAY_CYC(D)) u_q (
			.mclk   (mclk),
			.rst    (rst),
			.clk_en (clk_en),
			.q      (qi)
		);
		assign hit[i] = qi.hit;
	end

	// R1 short condition
	assign scp_now = sv[S_CS_OVL] && sv[S_VCC_SCP];
	assign latch_trip = hit[Q_LAT_HI] || hit[Q_LAT_LO] || hit[Q_OV];

	always_comb begin
		state_d = state_q;
		case (state_q)
			// R14 start threshold
			ST_UNDERVOLTAGE_LOCKOUT: begin
				if (sv[S_VCC_ON] && !sv[S_VCC_OFF])
					state_d = ST_RUN;
			end
			ST_RUN: begin
				// R3 latch variant on short
				if (scp_now)
					state_d = variant_q ? ST_LATCHED : ST_SCP_WAIT;
				// R9 brown-out stop
				else if (hit[Q_BO])
					state_d = ST_BROWNOUT;
			end
			// R2 timed restart
			ST_SCP_WAIT: begin
				if (restart_q == RW'(RESTART - 1))
					state_d = ST_RUN;
			end
			// R11 brown-in restart
			ST_BROWNOUT: begin
				if (sv[S_VH_BI])
					state_d = ST_RUN;
			end
			ST_LATCHED: state_d = ST_LATCHED;
			default:    state_d = ST_UNDERVOLTAGE_LOCKOUT;
		endcase
		// R20 latch priority
		if (state_q != ST_UNDERVOLTAGE_LOCKOUT && latch_trip)
			state_d = ST_LATCHED;
		// R15 lockout overrides every other next state, latch included
		if (sv[S_VCC_OFF])
			state_d = ST_UNDERVOLTAGE_LOCKOUT;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= ST_UNDERVOLTAGE_LOCKOUT;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// R2 restart timer
	always_ff @(posedge mclk) begin
		if (rst) begin
			restart_q <= '0;
		end else if (clk_en) begin
			if (state_q == ST_SCP_WAIT)
				restart_q <= restart_q + 1'b1;
			else
				restart_q <= '0;
		end
	end

	// R7 eight-level quantiser, one level of hysteresis on the way down
	always_ff @(posedge mclk) begin
		if (rst) begin
			vh_lvl_q <= '0;
			vh_inc_q <= 1'b0;
		end else if (clk_en) begin
			vh_inc_q <= 1'b0;
			if (vh_lvl_q < 3'(VH_LEVELS - 1) && sv[S_THERM + vh_lvl_q]) begin
				vh_lvl_q <= vh_lvl_q + 1'b1;
				vh_inc_q <= 1'b1;
			end else if (vh_lvl_q >= 3'h2
				&& !sv[S_THERM + 3'(vh_lvl_q - 3'h2)]) begin
				vh_lvl_q <= vh_lvl_q - 1'b1;
			end
		end
	end

	// R7 detection window
	always_ff @(posedge mclk) begin
		if (rst) begin
			win_q     <= '0;
			seen_q    <= 1'b0;
			ac_lost_q <= 1'b0;
		end else if (clk_en) begin
			if (win_q == AW'(ACDET - 1)) begin
				win_q     <= '0;
				seen_q    <= 1'b0;
				// R6 no rise seen, treat line as cut
				ac_lost_q <= !(seen_q || vh_inc_q);
			end else begin
				win_q <= win_q + 1'b1;
				if (vh_inc_q)
					seen_q <= 1'b1;
			end
			// A rising level proves the line is back straight away
			if (vh_inc_q)
				ac_lost_q <= 1'b0;
		end
	end

	// R8 discharge on/off pulsing
	always_ff @(posedge mclk) begin
		if (rst) begin
			xcd_cnt_q <= '0;
			xcd_on_q  <= 1'b1;
			xcd_q     <= 1'b0;
		end else if (clk_en) begin
			if (!ac_lost_q) begin
				xcd_cnt_q <= '0;
				xcd_on_q  <= 1'b1;
			end else if (xcd_on_q && xcd_cnt_q == XW'(XCD_ON - 1)) begin
				xcd_cnt_q <= '0;
				xcd_on_q  <= 1'b0;
			end else if (!xcd_on_q && xcd_cnt_q == XW'(XCD_OFF - 1)) begin
				xcd_cnt_q <= '0;
				xcd_on_q  <= 1'b1;
			end else begin
				xcd_cnt_q <= xcd_cnt_q + 1'b1;
			end
			// R6 discharge drive
			xcd_q <= ac_lost_q && xcd_on_q;
		end
	end

	// R18 period from feedback level, R12 spread added, capped at floor
	always_comb begin
		int p;
		p = PER_MAX_CYC - ((PER_MAX_CYC - PER_NOM_CYC)
			* int'(sv[S_FB +: FB_W])) / (FB_LEVELS - 1);
		p = p + int'(dith_q);
		if (p > PER_MAX_CYC)
			p = PER_MAX_CYC;
		per_d = PW'(p);
	end

	assign wrap = per_cnt_q >= per_len_q - 1'b1;

	always_ff @(posedge mclk) begin
		if (rst) begin
			per_cnt_q <= '0;
			per_len_q <= PW'(PER_NOM_CYC);
		end else if (clk_en) begin
			if (wrap) begin
				per_cnt_q <= '0;
				per_len_q <= per_d;
			end else begin
				per_cnt_q <= per_cnt_q + 1'b1;
			end
		end
	end

	// R12 triangle sweep, one step per switching period
	always_ff @(posedge mclk) begin
		if (rst) begin
			dith_q    <= '0;
			dith_up_q <= 1'b1;
		end else if (clk_en && wrap) begin
			if (dith_up_q) begin
				dith_q <= dith_q + 8'sh01;
				if (dith_q >= 8'(DITH_CYC - 1))
					dith_up_q <= 1'b0;
			end else begin
				dith_q <= dith_q - 8'sh01;
				if (dith_q <= 8'(1 - DITH_CYC))
					dith_up_q <= 1'b1;
			end
		end
	end

	// R5 soft-start ramp, restarted on every entry to run
	always_ff @(posedge mclk) begin
		if (rst) begin
			ss_lim_q <= '0;
			ss_div_q <= '0;
		end else if (clk_en) begin
			if (state_q != ST_RUN) begin
				ss_lim_q <= '0;
				ss_div_q <= '0;
			end else if (ss_div_q == SW'(SS_STEP - 1)) begin
				ss_div_q <= '0;
				if (ss_lim_q != PW'(PER_MAX_CYC))
					ss_lim_q <= ss_lim_q + 1'b1;
			end else begin
				ss_div_q <= ss_div_q + 1'b1;
			end
		end
	end

	// R17 burst pause, R1 immediate stop
	assign sw_en = state_q == ST_RUN && !sv[S_FB_BURST] && !scp_now;

	always_ff @(posedge mclk) begin
		if (rst) begin
			gate_q   <= 1'b0;
			on_cnt_q <= '0;
		end else if (clk_en) begin
			if (wrap) begin
				on_cnt_q <= '0;
				gate_q   <= sw_en && ss_lim_q != '0;
			end else begin
				on_cnt_q <= on_cnt_q + 1'b1;
				// R19 current trip, R5 width limit
				if (!sw_en || sv[S_CS_PWM] || on_cnt_q + 1'b1 >= ss_lim_q)
					gate_q <= 1'b0;
			end
		end
	end

	// Start-up charger: full charge in lockout, off in run, hysteretic hold otherwise
	always_ff @(posedge mclk) begin
		if (rst) begin
			charger_q <= 1'b1;
		end else if (clk_en) begin
			case (state_d)
				ST_UNDERVOLTAGE_LOCKOUT: charger_q <= 1'b1;
				ST_RUN:  charger_q <= 1'b0;
				// R16 latched-off hold band
				ST_LATCHED: begin
					if (sv[S_LH_LO])
						charger_q <= 1'b1;
					else if (sv[S_LH_HI])
						charger_q <= 1'b0;
				end
				// R10 brown-out hold band
				ST_BROWNOUT, ST_SCP_WAIT: begin
					if (sv[S_RH_LO])
						charger_q <= 1'b1;
					else if (sv[S_RH_HI])
						charger_q <= 1'b0;
				end
				default: charger_q <= 1'b0;
			endcase
		end
	end

	// R15 gate held low outside run
	assign gate_out           = gate_q;
	assign charger_on         = charger_q;
	assign line_cap_discharge = xcd_q;
	assign ac_present         = !ac_lost_q;
	assign op_state           = state_q;
endmodule
`default_nettype wire

// ===== pwm_seq_pkg.sv
// Constants, timing counts and state codes of the protection sequencer
`default_nettype none
package pwm_seq_pkg;
	// Clock rate
	localparam int CLK_HZ  = 40_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;

	// Times as specified
	localparam int T_LAT_US     = 72;
	localparam int T_OV_US      = 72;
	localparam int T_BO_MS      = 65;
	localparam int T_RESTART_MS = 1400;
	localparam int T_ACDET_MS   = 56;
	localparam int T_XCD_ON_US  = 1500;
	localparam int T_XCD_OFF_US = 500;
	localparam int T_SS_US      = 10000;

	// Cycle counts derived from the times
	localparam int LAT_DLY_CYC = T_LAT_US * CLK_MHZ;
	localparam int OV_DLY_CYC  = T_OV_US * CLK_MHZ;
	localparam int BO_DLY_CYC  = T_BO_MS * CLK_KHZ;
	localparam int RESTART_CYC = T_RESTART_MS * CLK_KHZ;
	localparam int ACDET_CYC   = T_ACDET_MS * CLK_KHZ;
	localparam int XCD_ON_CYC  = T_XCD_ON_US * CLK_MHZ;
	localparam int XCD_OFF_CYC = T_XCD_OFF_US * CLK_MHZ;
	localparam int SS_CYC      = T_SS_US * CLK_MHZ;

	// Switching frequencies
	localparam int F_NOM_HZ    = 65000;
	localparam int F_MIN_HZ    = 25000;
	localparam int F_DEV_HZ    = 7000;
	localparam int PER_NOM_CYC = CLK_HZ / F_NOM_HZ;
	localparam int PER_MAX_CYC = CLK_HZ / F_MIN_HZ;
	localparam int DITH_CYC    = PER_NOM_CYC - CLK_HZ / (F_NOM_HZ + F_DEV_HZ);
	localparam int PW          = $clog2(PER_MAX_CYC + 1);

	// Quantiser sizes
	localparam int VH_LEVELS = 8;
	localparam int FB_LEVELS = 16;
	localparam int FB_W      = $clog2(FB_LEVELS);

	// Qualifier channels
	localparam int Q_LAT_HI = 0;
	localparam int Q_LAT_LO = 1;
	localparam int Q_OV     = 2;
	localparam int Q_BO     = 3;
	localparam int Q_NUM    = 4;

	// Bit positions in the synchroniser vector
	localparam int S_CS_OVL   = 0;
	localparam int S_VCC_SCP  = 1;
	localparam int S_LAT_HI   = 2;
	localparam int S_LAT_LO   = 3;
	localparam int S_OV       = 4;
	localparam int S_VCC_ON   = 5;
	localparam int S_VCC_OFF  = 6;
	localparam int S_VH_BO    = 7;
	localparam int S_VH_BI    = 8;
	localparam int S_FB_BURST = 9;
	localparam int S_CS_PWM   = 10;
	localparam int S_RH_LO    = 11;
	localparam int S_RH_HI    = 12;
	localparam int S_LH_LO    = 13;
	localparam int S_LH_HI    = 14;
	localparam int S_VARIANT  = 15;
	localparam int S_THERM    = 16;
	localparam int S_FB       = S_THERM + VH_LEVELS - 1;
	localparam int N_SYNC     = S_FB + FB_W;

	typedef enum logic [2:0] {
		ST_UNDERVOLTAGE_LOCKOUT     = 3'b000,
		ST_RUN      = 3'b001,
		ST_SCP_WAIT = 3'b010,
		ST_BROWNOUT = 3'b011,
		ST_LATCHED  = 3'b100
	} op_state_e;
endpackage
`default_nettype wire

// ===== qual_if.sv
// Condition and result of one fault qualification delay
`timescale 1ns/1ps
`default_nettype none
interface qual_if;
	logic cond;
	logic hit;
	modport filt (input cond, output hit);
	modport user (output cond, input hit);
endinterface
`default_nettype wire

// ===== seq_props.sv
// Concurrent checks on the protection sequencer ports
`timescale 1ns/1ps
`default_nettype none
module seq_props
	import pwm_seq_pkg::*;
#(
	parameter int RESTART = 300,
	parameter int XCD_ON  = 30
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       clk_en,
	// Comparators
	input wire logic       cs_overload,
	input wire logic       cs_pwm_trip,
	input wire logic       vcc_below_scp,
	input wire logic       vcc_above_start,
	input wire logic       vcc_below_stop,
	input wire logic       vcc_below_latch_hold_low,
	input wire logic       supply_overvoltage_protect,
	input wire logic       ext_latch_above_high,
	input wire logic       ext_latch_below_low,
	input wire logic       feedback_below_burst,
	input wire logic       latch_variant,
	// Outputs
	input wire logic       gate_out,
	input wire logic       charger_on,
	input wire logic       line_cap_discharge,
	input wire logic       ac_present,
	input wire logic [2:0] op_state
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst || !clk_en);
	logic [2:0] cf;
	int         lat_q [3];
	int         wait_q;
	int         dis_q;

	assign cf = {supply_overvoltage_protect, ext_latch_below_low,
		ext_latch_above_high};
	// Per channel, so a hand-over between faults cannot fake a long hold
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			if (rst || !cf[i] || op_state == ST_UNDERVOLTAGE_LOCKOUT) begin
				lat_q[i] <= 0;
			end else if (lat_q[i] < 4000) begin
				lat_q[i] <= lat_q[i] + 1;
			end
		end
	end
	always_ff @(posedge mclk) begin
		wait_q <= (!rst && op_state == ST_SCP_WAIT) ? wait_q + 1 : 0;
	end
	always_ff @(posedge mclk) begin
		dis_q <= (!rst && line_cap_discharge) ? dis_q + 1 : 0;
	end

	property p_start;
		(op_state == ST_UNDERVOLTAGE_LOCKOUT && vcc_above_start && !vcc_below_stop)[*3]
			|=> op_state == ST_RUN;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_stop;
		$rose(vcc_below_stop) |-> ##[1:4] op_state == ST_UNDERVOLTAGE_LOCKOUT;
	endproperty
	a_stop: assert property (p_stop) else $error("no lockout");
	property p_undervoltage_lockout_gate;
		(op_state == ST_UNDERVOLTAGE_LOCKOUT)[*2] |-> !gate_out;
	endproperty
	a_undervoltage_lockout_gate: assert property (p_undervoltage_lockout_gate) else $error("gate on");
	property p_latch_exit;
		$past(op_state) == ST_LATCHED && op_state != ST_LATCHED
			|-> op_state == ST_UNDERVOLTAGE_LOCKOUT;
	endproperty
	a_latch_exit: assert property (p_latch_exit) else $error("left");
	property p_scp;
		(op_state == ST_RUN && cs_overload && vcc_below_scp)[*3]
			|=> op_state != ST_RUN;
	endproperty
	a_scp: assert property (p_scp) else $error("no short stop");
	property p_wait_var;
		$rose(op_state == ST_SCP_WAIT) |-> !latch_variant;
	endproperty
	a_wait_var: assert property (p_wait_var) else $error("variant");
	property p_restart;
		$past(op_state) == ST_SCP_WAIT && op_state == ST_RUN
			|-> wait_q inside {[RESTART - 2:RESTART + 2]};
	endproperty
	a_restart: assert property (p_restart) else $error("restart");
	property p_lat_fire;
		lat_q[0] == 2883 || lat_q[1] == 2883 || lat_q[2] == 2883
			|-> op_state == ST_LATCHED;
	endproperty
	a_lat_fire: assert property (p_lat_fire) else $error("no latch");
	property p_burst;
		feedback_below_burst[*4] |-> !$rose(gate_out);
	endproperty
	a_burst: assert property (p_burst) else $error("burst pulse");
	property p_trip;
		cs_pwm_trip[*3] ##1 gate_out |=> !gate_out;
	endproperty
	a_trip: assert property (p_trip) else $error("trip ignored");
	property p_lchg;
		(op_state == ST_LATCHED && vcc_below_latch_hold_low)[*4]
			|-> charger_on;
	endproperty
	a_lchg: assert property (p_lchg) else $error("charger off");
	property p_xcd;
		ac_present[*2] |-> !line_cap_discharge;
	endproperty
	a_xcd: assert property (p_xcd) else $error("discharge");
	property p_xcd_on;
		dis_q <= XCD_ON + 1;
	endproperty
	a_xcd_on: assert property (p_xcd_on) else $error("long pulse");
	c_latch: cover property ($rose(op_state == ST_LATCHED));
	c_wait: cover property ($rose(op_state == ST_SCP_WAIT));
	c_xcd: cover property ($rose(line_cap_discharge));
endmodule
bind pwm_protection_sequencer seq_props #(
	.RESTART(RESTART),
	.XCD_ON (XCD_ON)
) seq_props_inst (
	.mclk(mclk), .rst(rst), .clk_en(clk_en), .cs_overload(cs_overload),
	.cs_pwm_trip(cs_pwm_trip), .vcc_below_scp(vcc_below_scp),
	.vcc_above_start(vcc_above_start), .vcc_below_stop(vcc_below_stop),
	.vcc_below_latch_hold_low(vcc_below_latch_hold_low),
	.supply_overvoltage_protect(supply_overvoltage_protect),
	.ext_latch_above_high(ext_latch_above_high),
	.ext_latch_below_low(ext_latch_below_low),
	.feedback_below_burst(feedback_below_burst),
	.latch_variant(latch_variant), .gate_out(gate_out),
	.charger_on(charger_on), .line_cap_discharge(line_cap_discharge),
	.ac_present(ac_present), .op_state(op_state)
);
`default_nettype wire

// ===== supply_model.sv
// Behavioural supply rail, its comparators and the switch current sense
`timescale 1ns/1ps
`default_nettype none
module supply_model (
	// Clock
	input  wire logic        mclk,
	// Bench control, rail in tenths of a volt
	input  wire logic        set_en,
	input  wire logic [8:0]  set_val,
	input  wire logic        drift,
	input  wire logic [11:0] trip_dly,
	// From the sequencer
	input  wire logic        charger_on,
	input  wire logic        gate_out,
	// Comparator outputs
	output logic             vcc_below_scp,
	output logic             vcc_ov,
	output logic             vcc_above_start,
	output logic             vcc_below_stop,
	output logic             run_lo,
	output logic             run_hi,
	output logic             lat_lo,
	output logic             lat_hi,
	output logic             cs_pwm_trip,
	output logic [8:0]       vcc
);
	logic [1:0]  div_q;
	logic [11:0] cur_q;

	// Slow slope so the hold bands can be watched
	always @(posedge mclk) begin
		div_q <= div_q + 2'h1;
		if (set_en) begin
			vcc <= set_val;
		end else if (drift && div_q == 2'h0) begin
			vcc <= charger_on ? vcc + 9'h001 : vcc - 9'h001;
		end
	end
	// Switch current ramps only while the gate is on
	always @(posedge mclk) begin
		cur_q <= gate_out ? cur_q + 12'h001 : 12'h000;
	end
	initial div_q = 2'h0;
	initial cur_q = 12'h000;
	initial vcc = 9'h032;
	assign cs_pwm_trip     = gate_out && cur_q >= trip_dly;
	assign vcc_below_scp   = vcc < 9'd100;
	assign vcc_ov          = vcc > 9'd255;
	assign vcc_above_start = vcc >= 9'd130;
	assign vcc_below_stop  = vcc <= 9'd65;
	assign run_lo          = vcc < 9'd115;
	assign run_hi          = vcc > 9'd125;
	assign lat_lo          = vcc < 9'd80;
	assign lat_hi          = vcc > 9'd90;
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench of the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pwm_seq_pkg::*;
	logic        mclk = 1'b0, rst = 1'b1, set_en = 1'b1, drift = 1'b0;
	logic [8:0]  set_val = 9'd50;
	logic [11:0] trip_dly = 12'd400;
	logic        cs_ovl = 1'b0, lhi = 1'b0, llo = 1'b0, vlo = 1'b0;
	logic        vbi = 1'b1, burst = 1'b0, lvar = 1'b0, ac_on = 1'b1;
	logic [6:0]  therm = 7'h07;
	logic [3:0]  fb = 4'hf;
	logic        trip, b_scp, ov, a_st, b_st, rlo, rhi, llo_h, lhi_h;
	logic        gate, chg, dis, acp, en = 1'b1;
	logic [2:0]  st;
	logic [8:0]  vcc;
	logic [15:0] rnd = 16'h0020;
	int          n_errors = 0, cmp_count = 0, cyc = 0, w, p, lo, hi, nom;

	always #12.5 mclk = ~mclk;
	supply_model supply_model_inst (.mclk(mclk), .set_en(set_en),
		.set_val(set_val), .drift(drift), .trip_dly(trip_dly),
		.charger_on(chg), .gate_out(gate), .vcc_below_scp(b_scp),
		.vcc_ov(ov), .vcc_above_start(a_st), .vcc_below_stop(b_st),
		.run_lo(rlo), .run_hi(rhi), .lat_lo(llo_h), .lat_hi(lhi_h),
		.cs_pwm_trip(trip), .vcc(vcc));
	pwm_protection_sequencer #(.BO_DLY(200), .RESTART(300), .ACDET(500),
		.XCD_ON(30), .XCD_OFF(10), .SOFT_START(32000)
	) pwm_protection_sequencer_inst (.mclk(mclk), .rst(rst),
		.clk_en(en), .cs_overload(cs_ovl), .cs_pwm_trip(trip),
		.vcc_below_scp(b_scp), .supply_overvoltage_protect(ov),
		.vcc_above_start(a_st), .vcc_below_stop(b_st),
		.vcc_below_run_hold_low(rlo), .vcc_above_run_hold_high(rhi),
		.vcc_below_latch_hold_low(llo_h),
		.vcc_above_latch_hold_high(lhi_h), .ext_latch_above_high(lhi),
		.ext_latch_below_low(llo), .vh_below_brown_out(vlo),
		.vh_above_brown_in(vbi), .vh_level_therm(therm),
		.feedback_below_burst(burst), .feedback_level(fb),
		.latch_variant(lvar), .gate_out(gate), .charger_on(chg),
		.line_cap_discharge(dis), .ac_present(acp), .op_state(st));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic vset(input logic [8:0] v);
		set_val = v;
		tick(1);
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim);
		for (int i = 0; i < lim && st !== s; i++) tick(1);
		check("op_state", s, st);
	endtask
	task automatic gate_meas();
		for (int i = 0; i < 4000 && gate === 1'b1; i++) tick(1);
		for (int i = 0; i < 4000 && gate !== 1'b1; i++) tick(1);
		for (w = 0; w < 4000 && gate === 1'b1; w++) tick(1);
		for (p = w; p < 4000 && gate !== 1'b1; p++) tick(1);
	endtask
	task automatic band(input int n);
		lo = 511;
		hi = 0;
		repeat (n) begin
			tick(1);
			lo = (vcc < lo) ? vcc : lo;
			hi = (vcc > hi) ? vcc : hi;
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A level rise every 128 cycles stands for a live line
	always @(posedge mclk) begin
		cyc++;
		if (cyc % 64 == 0 && ac_on) therm <= #2 therm ^ 7'h38;
		if (cyc == 90000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		tick(5);
		rst = 1'b0;
		check("reset", 16'h0028, {gate, chg, dis, acp, st});
		vset(9'd140);
		wait_st(ST_RUN, 8);
		gate_meas();
		nom = w;
		tick(11000);
		gate_meas();
		check("soft start", 1, nom < w);
		check("trip end", 1, w > 400 && w < 406);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			fb = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : rnd[3:0];
			trip_dly = 12'd16 + rnd[8:0];
			gate_meas();
			gate_meas();
			nom = 1600 - 985 * fb / 15;
			check("period", 1, p > nom - 63 && p < nom + 63);
			check("cap", 1, p < 1602);
			check("width", 1, w > trip_dly && w < trip_dly + 6);
		end
		burst = 1'b1;
		tick(6);
		w = 0;
		repeat (2000) begin
			tick(1);
			w += gate;
		end
		check("burst", 0, w);
		burst = 1'b0;
		gate_meas();
		check("resume", 1, w > 0);
		vlo = 1'b1;
		vbi = 1'b0;
		tick(150);
		vlo = 1'b0;
		tick(10);
		vlo = 1'b1;
		tick(190);
		check("bo early", ST_RUN, st);
		wait_st(ST_BROWNOUT, 30);
		vset(9'd120);
		set_en = 1'b0;
		drift = 1'b1;
		band(600);
		check("bo band", 1, lo > 112 && hi < 128);
		set_en = 1'b1;
		drift = 1'b0;
		vset(9'd140);
		vlo = 1'b0;
		vbi = 1'b1;
		wait_st(ST_RUN, 8);
		vset(9'd95);
		cs_ovl = 1'b1;
		wait_st(ST_SCP_WAIT, 6);
		tick(2);
		check("scp gate", 0, gate);
		tick(285);
		check("scp hold", ST_SCP_WAIT, st);
		wait_st(ST_RUN, 20);
		wait_st(ST_SCP_WAIT, 6);
		cs_ovl = 1'b0;
		vset(9'd140);
		wait_st(ST_RUN, 320);
		for (int k = 0; k < 3; k++) begin
			{lhi, llo} = {k == 0, k == 1};
			set_val = (k == 2) ? 9'd260 : 9'd140;
			tick(2000);
			{lhi, llo} = 2'b00;
			vset(9'd140);
			tick(5);
			{lhi, llo} = {k == 0, k == 1};
			set_val = (k == 2) ? 9'd260 : 9'd140;
			tick(2870);
			check("lat early", ST_RUN, st);
			wait_st(ST_LATCHED, 40);
			{lhi, llo, vlo} = 3'b001;
			vset(9'd85);
			set_en = 1'b0;
			drift = 1'b1;
			band(400);
			check("lat band", 1, lo > 77 && hi < 93);
			check("lat prio", ST_LATCHED, st);
			{set_en, drift, vlo} = 3'b100;
			vset(9'd60);
			wait_st(ST_UNDERVOLTAGE_LOCKOUT, 8);
			vset(9'd140);
			wait_st(ST_RUN, 8);
		end
		vset(9'd60);
		lvar = 1'b1;
		tick(8);
		en = 1'b0;
		vset(9'd140);
		tick(9);
		check("frozen", ST_UNDERVOLTAGE_LOCKOUT, st);
		en = 1'b1;
		wait_st(ST_RUN, 8);
		vset(9'd95);
		cs_ovl = 1'b1;
		wait_st(ST_LATCHED, 8);
		cs_ovl = 1'b0;
		vset(9'd60);
		lvar = 1'b0;
		ac_on = 1'b0;
		for (int i = 0; i < 1100 && acp !== 1'b0; i++) tick(1);
		check("ac lost", 0, acp);
		for (int i = 0; i < 60 && dis !== 1'b0; i++) tick(1);
		for (int i = 0; i < 60 && dis !== 1'b1; i++) tick(1);
		for (w = 0; w < 99 && dis === 1'b1; w++) tick(1);
		for (p = 0; p < 99 && dis !== 1'b1; p++) tick(1);
		check("xcd on", 1, w > 28 && w < 33);
		check("xcd off", 1, p > 8 && p < 13);
		ac_on = 1'b1;
		for (int i = 0; i < 200 && acp !== 1'b1; i++) tick(1);
		tick(3);
		check("ac back", 16'h0002, {acp, dis});
		vset(9'd140);
		wait_st(ST_RUN, 8);
		rst = 1'b1;
		tick(3);
		check("mid reset", 16'h0028, {gate, chg, dis, acp, st});
		conclude();
	end
endmodule
`default_nettype wire
